// >>> flash_program_erase_sequencer.sv
// Embedded program and erase sequencer for a small flip-flop flash array.
//
// Functional notes
// - Busy reads return poll, toggle, error, window bits.
// - Erase sets ones; programming only clears bits.
// - Program poll bit reads inverted until done.
// - Erase poll bit reads zero, any erasing location.
// - Toggle bit flips per read while busy.
// - Error flag on failed program bit.
// - Unlock, unlock, 20h enters bypass mode.
// - Bypass programs with A0h then address/data.
// - Bypass exits with 90h then 00h.
// - Bulk erase needs six correct writes.
// - Erase preprograms to 00h, then erases.
// - Bulk erase ignores all commands.
// - Extra sector codes restart the erase window.
// - Window flag zero while counting, one during sector erase; zero in bulk erase.
// - Other commands in window, except B0h, abort to read.
// - Sector erasing accepts only reset and suspend.
// - B0h suspends erase, ends open window.
// - Toggle stops after suspend latency, read mode.
// - Suspended erasing sector reads invalid; resume/reset only.
// - 30h resumes suspended sector erase.
// - Commands start AAh at 555h, 55h at AAAh.
// - Any sector select enables command reception.
// - Bad byte or inter-byte timeout returns read.
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module flash_program_erase_sequencer #(
   parameter int unsigned WINDOW_CYCLES = flash_seq_pkg::WINDOW_CYCLES_DEF,
   parameter int unsigned PROG_CYCLES = flash_seq_pkg::PROG_CYCLES_DEF,
   parameter int unsigned ERASE_CYCLES = flash_seq_pkg::ERASE_CYCLES_DEF,
   parameter int unsigned CMD_TIMEOUT = flash_seq_pkg::CMD_TIMEOUT_DEF
) (
   // Clock, reset and enable.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Microcontroller bus as Avalon-MM slave.
   input wire logic [flash_seq_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [flash_seq_pkg::DATA_W-1:0] writedata,
   output logic [flash_seq_pkg::DATA_W-1:0] readdata,
   output logic waitrequest,
   // Sector selects from the address decoder.
   input wire flash_seq_pkg::sector_sel_type sel
);
   import flash_seq_pkg::*;

   // Counters start at zero, so each end point is the count minus one.
   localparam logic [CNT_W-1:0] WINDOW_LAST = CNT_W'(WINDOW_CYCLES - 1);
   localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);
   localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(ERASE_CYCLES - 1);
   localparam logic [CNT_W-1:0] TIMEOUT_LAST = CNT_W'(CMD_TIMEOUT - 1);
   localparam logic [SUSP_W-1:0] SUSP_LAST = SUSP_W'(SUSP_CYCLES - 1);

   seq_regs_type r;
   seq_regs_type n;

   // Secondary sectors win when both arrays are selected.
   function automatic logic [SECT_IDX_W-1:0] sect_of(sector_sel_type s);
      logic [SECT_IDX_W-1:0] idx;
      idx = '0;
      for (int i = 0; i < NUM_PRI; i++) begin
         if (s.primary_sector_selects[i]) begin
            idx = SECT_IDX_W'(i);
         end
      end
      for (int i = 0; i < NUM_SEC; i++) begin
         if (s.secondary_sector_selects[i]) begin
            idx = SECT_IDX_W'(NUM_PRI + i);
         end
      end
      return idx;
   endfunction : sect_of

   always_comb begin
      logic sel_any;
      logic [SECT_IDX_W-1:0] sidx;
      logic [MEM_AW-1:0] idx;
      logic [11:0] a12;
      logic [7:0] wd;
      logic wr;
      logic status_mode;
      logic [7:0] stat;
      logic [7:0] merged;
      logic erase_on;
      logic erase_end;
      sel_any = |sel;
      sidx = sect_of(sel);
      idx = {sidx, address[SECT_AW-1:0]};
      a12 = address[11:0];
      wd = writedata;
      wr = 1'b0;
      stat = '0;
      merged = '0;
      erase_on = 1'b0;
      erase_end = 1'b0;
      n = r;

      status_mode = (r.state == ST_PROGRAM) || (r.state == ST_PROG_FAIL) ||
         (r.state == ST_BULK) || (r.state == ST_SE_WINDOW) ||
         (r.state == ST_SE_BUSY) || (r.state == ST_SUSP_PEND);

      // Status byte; undefined bits read as zero.
      stat[BIT_TOGGLE] = r.toggle;
      stat[BIT_ERROR] = (r.state == ST_PROG_FAIL);
      if ((r.state == ST_PROGRAM) || (r.state == ST_PROG_FAIL)) begin
         stat[BIT_POLL] = ~r.prog_data[7];
      end else begin
         stat[BIT_POLL] = 1'b0;
      end
      stat[BIT_WINDOW] = (r.state == ST_SE_BUSY) ||
         (r.state == ST_SUSP_PEND);

      // One wait cycle per access; the request completes at the next edge.
      n.ack = 1'b0;
      if ((read || write) && !r.ack) begin
         n.ack = 1'b1;
         if (read) begin
            if (!sel_any) begin
               n.rdata = UNSELECTED_BYTE;
            end else if (status_mode) begin
               n.rdata = stat;
            end else if ((r.state == ST_SUSPENDED) &&
               r.erase_mask[sidx]) begin
               n.rdata = INVALID_BYTE;
            end else begin
               n.rdata = r.mem[idx];
            end
         end
      end
      n.stall = ~n.ack;

      // Each completed status read flips the toggle flag.
      if (read && r.ack && sel_any && status_mode) begin
         n.toggle = ~r.toggle;
      end

      // Writes without any sector select are not commands.
      wr = write && r.ack && sel_any;

      case (r.state)
         ST_READ: begin
            // The gap timer stays parked at zero while idle.
            n.cnt = '0;
            if (wr && (wd == CMD_UNLOCK1) && (a12 == UNLOCK_ADDR1)) begin
               n.state = ST_CMD1;
            end
         end
         ST_CMD1, ST_CMD2, ST_PROG_ADDR, ST_ERASE1, ST_ERASE2,
         ST_ERASE3: begin
            // Every accepted byte restarts the gap timer; a wrong one ends it.
            n.cnt = r.cnt + 1'b1;
            if (wr) begin
               n.cnt = '0;
               n.state = ST_READ;
               case (r.state)
                  ST_CMD1: begin
                     if ((wd == CMD_UNLOCK2) && (a12 == UNLOCK_ADDR2)) begin
                        n.state = ST_CMD2;
                     end
                  end
                  ST_CMD2: begin
                     if (a12 == UNLOCK_ADDR1) begin
                        if (wd == CMD_PROGRAM) begin
                           n.state = ST_PROG_ADDR;
                        end else if (wd == CMD_BYPASS) begin
                           n.state = ST_BYPASS;
                        end else if (wd == CMD_ERASE_SETUP) begin
                           n.state = ST_ERASE1;
                        end
                     end
                  end
                  ST_PROG_ADDR: begin
                     // Any data is taken; a bad byte shows as an error later.
                     n.state = ST_PROGRAM;
                     n.byp = 1'b0;
                     n.prog_idx = idx;
                     n.prog_data = wd;
                  end
                  ST_ERASE1: begin
                     if ((wd == CMD_UNLOCK1) && (a12 == UNLOCK_ADDR1)) begin
                        n.state = ST_ERASE2;
                     end
                  end
                  ST_ERASE2: begin
                     if ((wd == CMD_UNLOCK2) && (a12 == UNLOCK_ADDR2)) begin
                        n.state = ST_ERASE3;
                     end
                  end
                  default: begin
                     // Sixth write picks bulk or sector erase.
                     n.phase = 1'b0;
                     if ((wd == CMD_BULK_ERASE) && (a12 == UNLOCK_ADDR1)) begin
                        n.state = ST_BULK;
                        n.erase_mask = '1;
                     end else if (wd == CMD_SECTOR_ERASE) begin
                        n.state = ST_SE_WINDOW;
                        n.erase_mask = '0;
                        n.erase_mask[sidx] = 1'b1;
                     end
                  end
               endcase
            end else if (r.cnt == TIMEOUT_LAST) begin
               n.cnt = '0;
               n.state = ST_READ;
            end
         end

         ST_PROGRAM: begin
            // Commands are ignored until the byte is done.
            n.cnt = r.cnt + 1'b1;
            if (r.cnt == PROG_LAST) begin
               n.cnt = '0;
               merged = r.mem[r.prog_idx] & r.prog_data;
               n.mem[r.prog_idx] = merged;
               if (merged != r.prog_data) begin
                  n.state = ST_PROG_FAIL;
               end else if (r.byp) begin
                  n.state = ST_BYPASS;
               end else begin
                  n.state = ST_READ;
               end
            end
         end

         ST_PROG_FAIL: begin
            // A failed byte holds the error until a reset command.
            if (wr && (wd == CMD_RESET)) begin
               n.state = r.byp ? ST_BYPASS : ST_READ;
            end
         end

         ST_BULK: begin
            // No byte is decoded here, not even the reset code.
            erase_on = 1'b1;
         end

         ST_SE_WINDOW: begin
            // The resume code equals the sector code; here it adds a sector.
            n.cnt = r.cnt + 1'b1;
            if (wr) begin
               n.cnt = '0;
               if (wd == CMD_SECTOR_ERASE) begin
                  n.erase_mask[sidx] = 1'b1;
               end else if (wd == CMD_SUSPEND) begin
                  n.state = ST_SUSPENDED;
               end else begin
                  n.state = ST_READ;
                  n.erase_mask = '0;
               end
            end else if (r.cnt == WINDOW_LAST) begin
               n.cnt = '0;
               n.state = ST_SE_BUSY;
            end
         end

         ST_SE_BUSY: begin
            // A reset here leaves the sector partly erased.
            erase_on = 1'b1;
            if (wr && (wd == CMD_SUSPEND)) begin
               n.state = ST_SUSP_PEND;
               n.susp_cnt = '0;
            end else if (wr && (wd == CMD_RESET)) begin
               n.state = ST_READ;
               n.erase_mask = '0;
               erase_on = 1'b0;
            end
         end

         ST_SUSP_PEND: begin
            // Erase is frozen; the toggle keeps running for the latency.
            n.susp_cnt = r.susp_cnt + 1'b1;
            if (r.susp_cnt == SUSP_LAST) begin
               n.state = ST_SUSPENDED;
            end
         end

         ST_SUSPENDED: begin
            // Array reads are served; only resume and reset are decoded.
            if (wr && (wd == CMD_RESUME)) begin
               n.state = ST_SE_BUSY;
            end else if (wr && (wd == CMD_RESET)) begin
               // A half-erased sector is forced to a known invalid pattern
               // so that software cannot mistake it for good data.
               n.state = ST_READ;
               n.erase_mask = '0;
               for (int s = 0; s < NUM_SECT; s++) begin
                  if (r.erase_mask[s]) begin
                     for (int b = 0; b < SECT_BYTES; b++) begin
                        n.mem[s * SECT_BYTES + b] = INVALID_BYTE;
                     end
                  end
               end
            end
         end

         ST_BYPASS: begin
            // Unlock cycles are skipped; stray bytes are simply dropped.
            if (wr && (wd == CMD_PROGRAM)) begin
               n.state = ST_BYP_PROG;
            end else if (wr && (wd == CMD_BYP_EXIT1)) begin
               n.state = ST_BYP_EXIT;
            end
         end

         ST_BYP_PROG: begin
            if (wr) begin
               n.state = ST_PROGRAM;
               n.byp = 1'b1;
               n.cnt = '0;
               n.prog_idx = idx;
               n.prog_data = wd;
            end
         end

         ST_BYP_EXIT: begin
            // A wrong second byte falls back into bypass, not read mode.
            if (wr && (wd == CMD_BYP_EXIT2)) begin
               n.state = ST_READ;
               n.byp = 1'b0;
            end else if (wr) begin
               n.state = ST_BYPASS;
            end
         end

         default: begin
            // Unused encodings recover to read mode.
            n.state = ST_READ;
         end
      endcase

      // Two-phase erase: preprogram to zero, then erase to ones.
      // The count is kept across a suspend, so resume carries on.
      if (erase_on) begin
         n.cnt = r.cnt + 1'b1;
         erase_end = (r.cnt == ERASE_LAST);
         if (erase_end) begin
            n.cnt = '0;
            n.phase = ~r.phase;
            for (int s = 0; s < NUM_SECT; s++) begin
               if (r.erase_mask[s]) begin
                  for (int b = 0; b < SECT_BYTES; b++) begin
                     n.mem[s * SECT_BYTES + b] =
                        r.phase ? ERASED_BYTE : PREPROG_BYTE;
                  end
               end
            end
            if (r.phase) begin
               n.state = ST_READ;
               n.erase_mask = '0;
            end
         end
      end
   end

   // A low enable also stretches a waiting bus access.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         r <= SEQ_RESET;
      end else if (ce) begin
         r <= n;
      end
   end

   // Both outputs come straight from the state register.
   assign readdata = r.rdata;
   assign waitrequest = r.stall;

endmodule : flash_program_erase_sequencer

// >>> flash_seq_monitor.sv
// Port checker for the flash sequencer bus handshake and read path.
`timescale 1ns/100ps
module flash_seq_monitor (
   // Clock, reset and enable.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Bus.
   input wire logic [flash_seq_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [flash_seq_pkg::DATA_W-1:0] writedata,
   input wire logic [flash_seq_pkg::DATA_W-1:0] readdata,
   input wire logic waitrequest,
   // Sector selects.
   input wire flash_seq_pkg::sector_sel_type sel
);
   import flash_seq_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_req;
      (read || write) && waitrequest && ce;
   endsequence
   sequence s_ack;
      !waitrequest ##1 waitrequest;
   endsequence
   AST_ACK_ONE: assert property (s_req |=> s_ack)
      else $error("access not answered after one cycle");
   AST_ACK_PULSE: assert property (!waitrequest |=> waitrequest)
      else $error("answer held longer than one cycle");
   AST_NO_SPUR: assert property (!(read || write) |=> waitrequest)
      else $error("answer without a request");
   AST_ANS_CAUSE: assert property (
      !waitrequest |-> ($past(read) || $past(write)) && $past(waitrequest))
      else $error("answer not caused by a waiting request");
   AST_RD_HOLD: assert property (
      $changed(readdata) |-> !waitrequest && read)
      else $error("read data changed outside a read answer");
   AST_UNSEL: assert property (
      !waitrequest && read && sel == '0 |-> readdata == 8'h00)
      else $error("unselected read returned data");
   AST_FREEZE: assert property (
      !ce |=> $stable(waitrequest) && $stable(readdata))
      else $error("outputs moved while the enable was low");
   AST_RST_VAL: assert property (
      $fell(rst) |-> waitrequest && readdata == 8'h00)
      else $error("outputs not at reset values after reset");
endmodule : flash_seq_monitor
bind flash_program_erase_sequencer flash_seq_monitor flash_seq_monitor_i (
   .clk_sys, .rst, .ce, .address, .read, .write, .writedata, .readdata,
   .waitrequest, .sel);

// >>> flash_seq_pkg.sv
// Constants and types shared by the flash program and erase sequencer.
package flash_seq_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;
   localparam int NUM_PRI = 8;
   localparam int NUM_SEC = 4;
   localparam int NUM_SECT = 12;
   localparam int SECT_IDX_W = 4;
   localparam int SECT_AW = 2;
   localparam int SECT_BYTES = 4;
   localparam int MEM_AW = SECT_IDX_W + SECT_AW;
   localparam int MEM_BYTES = NUM_SECT * SECT_BYTES;
   localparam int CNT_W = 16;
   localparam int SUSP_W = 12;

   // Unlock addresses; the upper nibble of the address is ignored.
   localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
   localparam logic [11:0] UNLOCK_ADDR2 = 12'hAAA;

   // Command codes.
   localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_PROGRAM = 8'hA0;
   localparam logic [7:0] CMD_BYPASS = 8'h20;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
   localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
   localparam logic [7:0] CMD_RESET = 8'hF0;

   // Data values.
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] PREPROG_BYTE = 8'h00;
   localparam logic [7:0] INVALID_BYTE = 8'h00;
   localparam logic [7:0] UNSELECTED_BYTE = 8'h00;

   // Status bit positions.
   localparam int BIT_POLL = 7;
   localparam int BIT_TOGGLE = 6;
   localparam int BIT_ERROR = 5;
   localparam int BIT_WINDOW = 3;

   // Timing.
   localparam int CLK_PERIOD_NS = 10;
   localparam int WINDOW_US = 100;
   localparam int WINDOW_CYCLES_DEF = WINDOW_US * 1000 / CLK_PERIOD_NS;
   localparam int SUSP_MIN_NS = 100;
   localparam int SUSP_MAX_NS = 15000;
   localparam int SUSP_CYCLES_CALC =
      (SUSP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SUSP_CYCLES = (SUSP_CYCLES_CALC < 1) ? 1 : SUSP_CYCLES_CALC;
   localparam int PROG_CYCLES_DEF = 64;
   localparam int ERASE_CYCLES_DEF = 256;
   localparam int CMD_TIMEOUT_DEF = 2048;

   typedef enum logic [4:0] {
      ST_READ, ST_CMD1, ST_CMD2, ST_PROG_ADDR, ST_ERASE1, ST_ERASE2,
      ST_ERASE3, ST_PROGRAM, ST_PROG_FAIL, ST_BULK, ST_SE_WINDOW,
      ST_SE_BUSY, ST_SUSP_PEND, ST_SUSPENDED, ST_BYPASS, ST_BYP_PROG,
      ST_BYP_EXIT
   } seq_state_type;

   typedef struct packed {
      logic [NUM_SEC-1:0] secondary_sector_selects;
      logic [NUM_PRI-1:0] primary_sector_selects;
   } sector_sel_type;

   typedef struct packed {
      seq_state_type state;
      logic stall;
      logic ack;
      logic [DATA_W-1:0] rdata;
      logic toggle;
      logic byp;
      logic phase;
      logic [CNT_W-1:0] cnt;
      logic [SUSP_W-1:0] susp_cnt;
      logic [NUM_SECT-1:0] erase_mask;
      logic [MEM_AW-1:0] prog_idx;
      logic [DATA_W-1:0] prog_data;
      logic [MEM_BYTES-1:0][DATA_W-1:0] mem;
   } seq_regs_type;

   localparam seq_regs_type SEQ_RESET = '{
      state: ST_READ,
      stall: 1'b1,
      mem: {MEM_BYTES{ERASED_BYTE}},
      default: '0
   };

endpackage : flash_seq_pkg

// >>> mcu.sv
// Bus master model of the microcontroller that issues flash commands.
`timescale 1ns/100ps
module mcu (
   // Clock.
   input wire logic clk_sys,
   // Bus.
   output logic [flash_seq_pkg::ADDR_W-1:0] address,
   output logic read,
   output logic write,
   output logic [flash_seq_pkg::DATA_W-1:0] writedata,
   input wire logic [flash_seq_pkg::DATA_W-1:0] readdata,
   input wire logic waitrequest,
   output flash_seq_pkg::sector_sel_type sel
);
   import flash_seq_pkg::*;
   initial begin
      address = '0;
      read = 1'b0;
      write = 1'b0;
      writedata = '0;
      sel = '0;
   end
   // A released bus shows inverted address and data so stale values never match.
   task automatic acc(input logic we, input logic [15:0] a,
         input logic [7:0] d, input sector_sel_type s,
         output logic [7:0] q);
      @(posedge clk_sys);
      address <= a;
      writedata <= d;
      sel <= s;
      read <= !we;
      write <= we;
      do @(posedge clk_sys); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      sel <= '0;
      writedata <= ~d;
      address <= ~a;
   endtask : acc
   task automatic wr(input logic [15:0] a, input logic [7:0] d,
         input sector_sel_type s);
      logic [7:0] q;
      acc(1'b1, a, d, s, q);
   endtask : wr
   task automatic rd(input logic [15:0] a, input sector_sel_type s,
         output logic [7:0] q);
      acc(1'b0, a, 8'h00, s, q);
   endtask : rd
   task automatic cmd(input logic [7:0] c, input sector_sel_type s);
      wr({4'h0, UNLOCK_ADDR1}, CMD_UNLOCK1, s);
      wr({4'h0, UNLOCK_ADDR2}, CMD_UNLOCK2, s);
      wr({4'h0, UNLOCK_ADDR1}, c, s);
   endtask : cmd
   task automatic ers(input sector_sel_type s);
      cmd(CMD_ERASE_SETUP, s);
      wr({4'h0, UNLOCK_ADDR1}, CMD_UNLOCK1, s);
      wr({4'h0, UNLOCK_ADDR2}, CMD_UNLOCK2, s);
   endtask : ers
endmodule : mcu

// >>> tb_top.sv
// Self-checking bench for the flash program and erase sequencer.
`timescale 1ns/100ps
module tb_top;
   import flash_seq_pkg::*;
   localparam logic [15:0] UA1 = {4'h0, UNLOCK_ADDR1};
   logic clk_sys;
   logic rst;
   logic ce;
   logic [ADDR_W-1:0] address;
   logic read;
   logic write;
   logic [DATA_W-1:0] writedata;
   logic [DATA_W-1:0] readdata;
   logic waitrequest;
   sector_sel_type sel;
   int err_count;
   int total_checks;
   logic [7:0] r;
   logic [7:0] r2;
   flash_program_erase_sequencer #(.WINDOW_CYCLES(50), .PROG_CYCLES(20),
      .ERASE_CYCLES(20), .CMD_TIMEOUT(64)) flash_program_erase_sequencer_i (
      .clk_sys, .rst, .ce, .address, .read, .write, .writedata, .readdata,
      .waitrequest, .sel);
   mcu mcu_i (.clk_sys, .address, .read, .write, .writedata, .readdata,
      .waitrequest, .sel);
   function automatic sector_sel_type sl(input int i);
      return sector_sel_type'(12'h001 << i);
   endfunction : sl
   task automatic chk(input string n, input logic [7:0] s,
         input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic poll(input logic [15:0] a, input sector_sel_type s,
         input logic [7:0] e);
      logic [7:0] q;
      for (int i = 0; i < 100; i++) begin
         mcu_i.rd(a, s, q);
         if (q === e) break;
      end
      chk("poll", q, e);
   endtask : poll
   task automatic test_done;
      $display("Checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // The tests need under a thousand cycles; 20000 leaves ample margin.
   initial begin
      #200000;
      err_count++;
      test_done();
   end
   initial begin
      err_count = 0;
      total_checks = 0;
      rst = 1'b1;
      ce = 1'b1;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      ce <= 1'b0;
      repeat (2) @(posedge clk_sys);
      ce <= 1'b1;
      mcu_i.rd(16'h0001, '0, r);
      chk("unselected", r, UNSELECTED_BYTE);
      mcu_i.rd(16'h0001, sl(0), r);
      chk("blank", r, ERASED_BYTE);
      mcu_i.cmd(CMD_PROGRAM, sl(0));
      mcu_i.wr(16'h0001, 8'h5A, sl(0));
      mcu_i.rd(16'h0001, sl(0), r);
      mcu_i.rd(16'h0001, sl(0), r2);
      chk("prog status", r & 8'hBF, 8'h80);
      chk("toggle", r2 ^ r, 8'h40);
      poll(16'h0001, sl(0), 8'h5A);
      mcu_i.rd(16'h0001, sl(0), r2);
      chk("stopped", r2, 8'h5A);
      // Setting a cleared bit must fail and hold the error flag.
      mcu_i.cmd(CMD_PROGRAM, sl(0));
      mcu_i.wr(16'h0001, 8'hA5, sl(0));
      repeat (30) @(posedge clk_sys);
      mcu_i.rd(16'h0001, sl(0), r);
      chk("fail status", r & 8'hBF, 8'h20);
      mcu_i.rd(16'h0001, sl(0), r2);
      chk("fail recheck", r2 ^ r, 8'h40);
      mcu_i.wr(16'h0000, CMD_RESET, sl(0));
      mcu_i.rd(16'h0000, sl(0), r);
      chk("after reset cmd", r, ERASED_BYTE);
      mcu_i.cmd(CMD_BYPASS, sl(9));
      mcu_i.wr(16'h0000, CMD_PROGRAM, sl(9));
      mcu_i.wr(16'h0002, 8'h3C, sl(9));
      poll(16'h0002, sl(9), 8'h3C);
      mcu_i.wr(16'hF123, CMD_BYP_EXIT1, sl(9));
      mcu_i.wr(16'h0ABC, CMD_BYP_EXIT2, sl(9));
      mcu_i.wr(16'h0000, CMD_PROGRAM, sl(9));
      mcu_i.wr(16'h0003, 8'h00, sl(9));
      mcu_i.rd(16'h0003, sl(9), r);
      chk("bypass left", r, ERASED_BYTE);
      // Second sector code after 40 cycles must restart the window.
      mcu_i.ers(sl(0));
      mcu_i.wr(16'h0000, CMD_SECTOR_ERASE, sl(0));
      repeat (40) @(posedge clk_sys);
      mcu_i.wr(16'h0000, CMD_SECTOR_ERASE, sl(9));
      repeat (15) @(posedge clk_sys);
      mcu_i.rd(16'h0001, sl(0), r);
      chk("window", r & 8'hBF, 8'h00);
      repeat (40) @(posedge clk_sys);
      mcu_i.rd(16'h0002, sl(9), r);
      chk("erasing", r & 8'hBF, 8'h08);
      poll(16'h0002, sl(9), ERASED_BYTE);
      mcu_i.rd(16'h0001, sl(0), r);
      chk("erased", r, ERASED_BYTE);
      mcu_i.ers(sl(2));
      mcu_i.wr(16'h0000, CMD_SECTOR_ERASE, sl(2));
      repeat (55) @(posedge clk_sys);
      mcu_i.wr(16'h0000, CMD_SUSPEND, sl(2));
      poll(16'h0000, sl(2), INVALID_BYTE);
      mcu_i.rd(16'h0001, sl(3), r);
      chk("other sector", r, ERASED_BYTE);
      mcu_i.cmd(CMD_PROGRAM, sl(3));
      mcu_i.wr(16'h0001, 8'h00, sl(3));
      mcu_i.rd(16'h0001, sl(3), r);
      chk("no program", r, ERASED_BYTE);
      mcu_i.wr(16'h0000, CMD_RESUME, sl(2));
      poll(16'h0000, sl(2), ERASED_BYTE);
      mcu_i.ers(sl(4));
      mcu_i.wr(16'h0000, CMD_SECTOR_ERASE, sl(4));
      mcu_i.wr(16'h0000, CMD_PROGRAM, sl(4));
      mcu_i.rd(16'h0000, sl(4), r);
      chk("window abort", r, ERASED_BYTE);
      mcu_i.ers(sl(3));
      mcu_i.wr(16'h0000, CMD_SECTOR_ERASE, sl(3));
      repeat (55) @(posedge clk_sys);
      mcu_i.wr(16'h0000, CMD_RESET, sl(3));
      mcu_i.rd(16'h0001, sl(3), r);
      chk("busy reset", r, ERASED_BYTE);
      // Suspend inside the window; two reads rule out a toggling status.
      mcu_i.ers(sl(3));
      mcu_i.wr(16'h0000, CMD_SECTOR_ERASE, sl(3));
      mcu_i.wr(16'h0000, CMD_SUSPEND, sl(3));
      mcu_i.rd(16'h0001, sl(3), r);
      mcu_i.rd(16'h0001, sl(3), r2);
      chk("window suspend", r | r2, INVALID_BYTE);
      mcu_i.wr(16'h0000, CMD_RESET, sl(3));
      mcu_i.cmd(CMD_PROGRAM, sl(4));
      mcu_i.wr(16'h0003, 8'h00, sl(4));
      poll(16'h0003, sl(4), 8'h00);
      mcu_i.rd(16'h0001, sl(3), r);
      chk("reset invalid", r, INVALID_BYTE);
      mcu_i.cmd(CMD_PROGRAM, sl(5));
      mcu_i.wr(16'h0000, 8'h00, sl(5));
      poll(16'h0000, sl(5), 8'h00);
      mcu_i.ers(sl(5));
      mcu_i.wr(UA1, 8'h11, sl(5));
      mcu_i.rd(16'h0000, sl(5), r);
      chk("bulk abort", r, 8'h00);
      mcu_i.ers(sl(5));
      mcu_i.wr(UA1, CMD_BULK_ERASE, sl(5));
      mcu_i.cmd(CMD_PROGRAM, sl(6));
      mcu_i.wr(16'h0001, 8'h00, sl(6));
      poll(16'h0000, sl(5), ERASED_BYTE);
      mcu_i.rd(16'h0001, sl(6), r);
      chk("bulk ignores", r, ERASED_BYTE);
      mcu_i.wr(UA1, CMD_UNLOCK1, sl(7));
      repeat (70) @(posedge clk_sys);
      mcu_i.wr({4'h0, UNLOCK_ADDR2}, CMD_UNLOCK2, sl(7));
      mcu_i.wr(UA1, CMD_PROGRAM, sl(7));
      mcu_i.wr(16'h0000, 8'h00, sl(7));
      mcu_i.rd(16'h0000, sl(7), r);
      chk("byte timeout", r, ERASED_BYTE);
      test_done();
   end
endmodule : tb_top
